// ==== hw/dfm_defines.svh ====
// timing counts, field positions, address windows and reset values
// assumes a 250 MHz system clock and a character-cell raster
`ifndef DFM_DEFINES_SVH
`define DFM_DEFINES_SVH
// ****************************************************************
// clock and dot rate
// ****************************************************************
`define DFM_CLK_NS        4
`define DFM_DOT_NS        80
`define DFM_DOT_DIV       ((`DFM_DOT_NS + `DFM_CLK_NS - 1) / `DFM_CLK_NS)
// ****************************************************************
// raster geometry, in dots, cells and scan lines
// ****************************************************************
`define DFM_DOTS_PER_CELL 3'h7
`define DFM_COLS          7'h40
`define DFM_H_LAST        7'h4F
`define DFM_HSYNC_START   7'h44
`define DFM_HSYNC_END     7'h4A
`define DFM_SCAN_LAST     4'hB
`define DFM_GLYPH_ROWS    4'hA
`define DFM_V_ACTIVE      8'hC0
`define DFM_V_LAST        8'hDB
`define DFM_VSYNC_START   8'hC8
`define DFM_VSYNC_END     8'hCC
// ****************************************************************
// storage windows
// ****************************************************************
`define DFM_BUF_BASE      16'h0200
`define DFM_BUF_LAST      16'h05FF
`define DFM_HEX_BASE      16'h0000
`define DFM_HEX_LAST      16'h01FF
// ****************************************************************
// buffer entry fields and reset values
// ****************************************************************
`define DFM_ENT_BLANK     10
`define DFM_ENT_NIB       9
`define DFM_ENT_HEX       8
`define DFM_ENT_W         11
`define DFM_SPACE_CODE    8'h20
`define DFM_ADDR_RESET    16'h0000
`endif

// ==== hw/dfm_pkg.sv ====
// types shared by the display fetch block
// assumes nothing beyond the defines header
package dfm_pkg;
   // line width selection from the panel switch
   typedef enum logic [1:0] {
      DFM_WIDTH_FULL,
      DFM_WIDTH_LEFT,
      DFM_WIDTH_RIGHT
   } dfm_width_e;
   typedef logic [7:0] dfm_code_t;
endpackage

// ==== hw/dfm_buf.sv ====
// small ring buffer with valid/ready on both sides and a flush
// assumes one clock, synchronous active-low reset
module dfm_buf #(
   parameter int W     = 11,
   parameter int DEPTH = 2
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         flush,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = (DEPTH > 2) ? $clog2(DEPTH) : 1;
   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
         $error("dfm_buf depth must be a power of two of at least 2");
      end
   endgenerate
   logic [W-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [AW:0]   cnt_reg;
   wire do_wr = in_valid && in_ready && !flush;
   wire do_rd = out_valid && out_ready && !flush;
   // ****************************************************************
   // status and read port
   // ****************************************************************
   assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid = (cnt_reg != '0);
   assign out_data  = mem_reg[rd_reg];
   // storage written at the write index
   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem_reg[wr_reg] <= in_data;
      end
   end
   // pointers and fill count, flush empties the buffer
   always_ff @(posedge clk) begin
      if (!resetn || flush) begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         if (do_wr) wr_reg <= wr_reg + 1'b1;
         if (do_rd) rd_reg <= rd_reg + 1'b1;
         cnt_reg <= cnt_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end
endmodule

// ==== hw/dfm_top.sv ====
// display adapter: cycle-steal fetch, data register, dot output, sync
// assumes storage answers each request with a one-cycle mem_ack
`include "dfm_defines.svh"
// How it works
// - characters come from storage through cycle-steal reads.
// - each fetched character loads the data register, which picks the dots.
// - horizontal and vertical sync come from this block's own counters.
// - left half mode shows columns 0-31 with a blank between characters.
// - full mode shows all 64 columns with no inserted blanks.
// - right half mode shows columns 32-63 with a blank between characters.
// - register display mode shows storage bytes 0 to 511 in hex.
// - normal mode shows storage bytes from 0200 through 05FF.
// - reverse setting swaps character and background polarity.
// - while in process, no stealing and the screen is blank.
module dfm_top #(
   parameter int DOT_DIV = `DFM_DOT_DIV,
   parameter int DEPTH   = 2
) (
   input  wire logic  clk,
   input  wire logic  resetn,
   input  wire logic  left_half_expanded,
   input  wire logic  right_half_expanded,
   input  wire logic  reverse_video,
   input  wire logic  display_registers,
   input  wire logic  in_process,
   output logic       mem_req,
   output logic [15:0] mem_addr,
   input  wire logic  mem_ack,
   input  wire logic [7:0] mem_rdata,
   output logic [7:0] data_code,
   output logic       hsync,
   output logic       vsync,
   output logic       video
);
   generate
      if (DOT_DIV < 1 || DOT_DIV > 256) begin : g_bad
         $error("dfm_top dot divider out of range");
      end
   endgenerate
   // ****************************************************************
   // helper functions
   // ****************************************************************
   // source column for a screen column under the width setting
   function automatic logic [5:0] src_col(input dfm_pkg::dfm_width_e w,
                                          input logic [6:0] col);
      case (w)
         dfm_pkg::DFM_WIDTH_LEFT:  src_col = {1'b0, col[5:1]};
         dfm_pkg::DFM_WIDTH_RIGHT: src_col = {1'b1, col[5:1]};
         default:                  src_col = col[5:0];
      endcase
   endfunction
   // ascii-style hex digit code for a nibble
   function automatic dfm_pkg::dfm_code_t hex_char(input logic [3:0] n);
      hex_char = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
   endfunction
   // dot row of the character generator for one code and scan line
   function automatic logic [7:0] glyph(input dfm_pkg::dfm_code_t c,
                                        input logic [3:0] scan);
      if (c == `DFM_SPACE_CODE || scan >= `DFM_GLYPH_ROWS)
         glyph = 8'h00;
      else
         glyph = {c[6:0], 1'b0} ^ {4'h0, scan};
   endfunction
   // ****************************************************************
   // registers
   // ****************************************************************
   logic [7:0] div_reg;
   logic       dot_en_reg;
   logic [2:0] dot_reg;
   logic [6:0] hcell_reg;
   logic [7:0] vline_reg;
   logic [3:0] scan_reg;
   logic [3:0] row_reg;
   logic       hsync_reg, vsync_reg, video_reg;
   logic [7:0] shift_reg;
   logic [7:0] data_reg;
   logic       mem_req_reg;
   logic [15:0] mem_addr_reg;
   logic       f_on_reg, f_stale_reg, f_hex_reg;
   logic [6:0] f_col_reg;
   logic [3:0] f_row_reg;
   dfm_pkg::dfm_width_e f_w_reg;
   // ****************************************************************
   // raster decode
   // ****************************************************************
   wire cell_end  = dot_en_reg && (dot_reg == `DFM_DOTS_PER_CELL);
   wire h_wrap    = (hcell_reg == `DFM_H_LAST);
   wire last_line = (vline_reg == `DFM_V_LAST);
   wire scan_wrap = (scan_reg == `DFM_SCAN_LAST);
   wire [7:0] nl  = last_line ? 8'h00 : vline_reg + 8'h01;
   wire nl_vis    = (nl < `DFM_V_ACTIVE);
   wire [3:0] nl_row  = last_line ? 4'h0 : (scan_wrap ? row_reg + 4'h1 : row_reg);
   wire [3:0] nl_scan = (last_line || scan_wrap) ? 4'h0 : scan_reg + 4'h1;
   wire line_vis  = (vline_reg < `DFM_V_ACTIVE);
   wire cur_vis   = line_vis && (hcell_reg < `DFM_COLS);
   wire ncell_vis = h_wrap ? nl_vis
                  : (line_vis && (hcell_reg + 7'h01 < `DFM_COLS));
   wire ld_cell   = cell_end && ncell_vis;
   wire restart   = cell_end && (hcell_reg == `DFM_COLS - 7'h01);
   wire [3:0] g_scan = h_wrap ? nl_scan : scan_reg;
   // panel width setting, both sides at once falls back to full
   wire dfm_pkg::dfm_width_e width_sel =
        (left_half_expanded && !right_half_expanded) ? dfm_pkg::DFM_WIDTH_LEFT :
        (right_half_expanded && !left_half_expanded) ? dfm_pkg::DFM_WIDTH_RIGHT :
        dfm_pkg::DFM_WIDTH_FULL;
   // ****************************************************************
   // fetch decode
   // ****************************************************************
   logic        buf_in_ready, buf_out_valid;
   logic [`DFM_ENT_W-1:0] buf_out_data;
   wire [5:0] f_src   = src_col(f_w_reg, f_col_reg);
   wire f_blank_cell  = (f_w_reg != dfm_pkg::DFM_WIDTH_FULL) && f_col_reg[0];
   // nothing starts on the line-start edge, so old-line data never lands in the new line
   wire f_want        = f_on_reg && !restart && (f_col_reg < `DFM_COLS) && buf_in_ready;
   wire f_issue       = f_want && !mem_req_reg && !f_blank_cell && !in_process;
   wire blank_push    = f_want && !mem_req_reg && f_blank_cell;
   wire data_push     = mem_req_reg && mem_ack && !f_stale_reg;
   wire buf_in_valid  = blank_push || data_push;
   // hex view packs 32 bytes per row, normal view 64 characters per row
   wire [15:0] f_addr = f_hex_reg
        ? (`DFM_HEX_BASE + {7'h00, f_row_reg, f_src[5:1]})
        : (`DFM_BUF_BASE + {6'h00, f_row_reg, f_src});
   wire [`DFM_ENT_W-1:0] buf_in_data =
        {blank_push, f_src[0], f_hex_reg, data_push ? mem_rdata : `DFM_SPACE_CODE};
   // ****************************************************************
   // cell decode: entry to displayed code
   // ****************************************************************
   wire e_blank = !buf_out_valid || buf_out_data[`DFM_ENT_BLANK];
   wire [7:0] e_raw = buf_out_data[7:0];
   wire [7:0] e_hex = hex_char(buf_out_data[`DFM_ENT_NIB] ? e_raw[3:0]
                                                           : e_raw[7:4]);
   wire [7:0] e_code = e_blank ? `DFM_SPACE_CODE
                     : (buf_out_data[`DFM_ENT_HEX] ? e_hex : e_raw);
   // two-entry buffer between storage reads and the dot path
   dfm_buf #(
      .W     (`DFM_ENT_W),
      .DEPTH (DEPTH)
   ) u_buf (
      .clk       (clk),
      .resetn    (resetn),
      .flush     (restart),
      .in_valid  (buf_in_valid),
      .in_ready  (buf_in_ready),
      .in_data   (buf_in_data),
      .out_valid (buf_out_valid),
      .out_ready (ld_cell),
      .out_data  (buf_out_data)
   );
   // ****************************************************************
   // dot rate divider and raster counters
   // ****************************************************************
   // one-cycle dot enable every DOT_DIV clocks
   always_ff @(posedge clk) begin
      if (!resetn) begin
         div_reg    <= 8'h00;
         dot_en_reg <= 1'b0;
      end else begin
         dot_en_reg <= (div_reg == 8'(DOT_DIV - 1));
         div_reg    <= (div_reg == 8'(DOT_DIV - 1)) ? 8'h00 : div_reg + 8'h01;
      end
   end
   // dot, cell, line, scan and row counters start at the top left
   always_ff @(posedge clk) begin
      if (!resetn) begin
         dot_reg   <= 3'h0;
         hcell_reg <= 7'h00;
         vline_reg <= 8'h00;
         scan_reg  <= 4'h0;
         row_reg   <= 4'h0;
      end else if (dot_en_reg) begin
         dot_reg <= dot_reg + 3'h1;
         if (cell_end) begin
            hcell_reg <= h_wrap ? 7'h00 : hcell_reg + 7'h01;
            if (h_wrap) begin
               vline_reg <= nl;
               scan_reg  <= nl_scan;
               row_reg   <= nl_row;
            end
         end
      end
   end
   // sync pulses from the raster position
   always_ff @(posedge clk) begin
      if (!resetn) begin
         hsync_reg <= 1'b0;
         vsync_reg <= 1'b0;
      end else begin
         hsync_reg <= (hcell_reg >= `DFM_HSYNC_START) && (hcell_reg < `DFM_HSYNC_END);
         vsync_reg <= (vline_reg >= `DFM_VSYNC_START) && (vline_reg < `DFM_VSYNC_END);
      end
   end
   // ****************************************************************
   // cycle-steal fetch
   // ****************************************************************
   // line start latches the width and hex settings so a line never mixes modes
   always_ff @(posedge clk) begin
      if (!resetn) begin
         f_on_reg  <= 1'b0;
         f_col_reg <= 7'h00;
         f_row_reg <= 4'h0;
         f_hex_reg <= 1'b0;
         f_w_reg   <= dfm_pkg::DFM_WIDTH_FULL;
      end else if (restart) begin
         f_on_reg  <= nl_vis;
         f_col_reg <= 7'h00;
         f_row_reg <= nl_row;
         f_hex_reg <= display_registers;
         f_w_reg   <= width_sel;
      end else if (buf_in_valid) begin
         f_col_reg <= f_col_reg + 7'h01;
      end
   end
   // storage request held until acknowledged, late answers dropped
   always_ff @(posedge clk) begin
      if (!resetn) begin
         mem_req_reg  <= 1'b0;
         mem_addr_reg <= `DFM_ADDR_RESET;
         f_stale_reg  <= 1'b0;
      end else begin
         if (f_issue) begin
            mem_req_reg  <= 1'b1;
            mem_addr_reg <= f_addr;
         end else if (mem_ack) begin
            mem_req_reg <= 1'b0;
         end
         if (mem_req_reg && mem_ack)
            f_stale_reg <= 1'b0;
         else if (restart && mem_req_reg)
            f_stale_reg <= 1'b1;
      end
   end
   // ****************************************************************
   // data register, dot shifter and video
   // ****************************************************************
   // each visible cell loads the data register and its dot row together
   always_ff @(posedge clk) begin
      if (!resetn) begin
         data_reg  <= 8'h00;
         shift_reg <= 8'h00;
      end else if (ld_cell) begin
         data_reg  <= e_code;
         shift_reg <= glyph(e_code, g_scan);
      end else if (dot_en_reg) begin
         shift_reg <= {shift_reg[6:0], 1'b0};
      end
   end
   // background level follows the reverse setting
   always_ff @(posedge clk) begin
      if (!resetn) begin
         video_reg <= 1'b0;
      end else if (in_process || !cur_vis) begin
         video_reg <= reverse_video;
      end else begin
         video_reg <= shift_reg[7] ^ reverse_video;
      end
   end
   assign mem_req   = mem_req_reg;
   assign mem_addr  = mem_addr_reg;
   assign data_code = data_reg;
   assign hsync     = hsync_reg;
   assign vsync     = vsync_reg;
   assign video     = video_reg;
   // ****************************************************************
   // checks
   // ****************************************************************
   chk_req_held: assert property (@(posedge clk) disable iff (!resetn)
      mem_req_reg && !mem_ack |=> mem_req_reg && $stable(mem_addr_reg))
      else $error("request dropped before acknowledge");
   chk_normal_window: assert property (@(posedge clk) disable iff (!resetn)
      $rose(mem_req_reg) && !f_hex_reg |->
      mem_addr_reg >= `DFM_BUF_BASE && mem_addr_reg <= `DFM_BUF_LAST)
      else $error("normal fetch outside the display buffer");
   chk_hex_window: assert property (@(posedge clk) disable iff (!resetn)
      $rose(mem_req_reg) && f_hex_reg |-> mem_addr_reg <= `DFM_HEX_LAST)
      else $error("hex fetch outside the first 512 bytes");
   chk_full_addr: assert property (@(posedge clk) disable iff (!resetn)
      f_issue && f_w_reg == dfm_pkg::DFM_WIDTH_FULL && !f_hex_reg |=>
      mem_addr_reg == `DFM_BUF_BASE + {6'h00, $past(f_row_reg), $past(f_col_reg[5:0])})
      else $error("full width address wrong");
   chk_half_blank: assert property (@(posedge clk) disable iff (!resetn)
      buf_in_valid && f_w_reg != dfm_pkg::DFM_WIDTH_FULL && f_col_reg[0] |->
      buf_in_data[`DFM_ENT_BLANK])
      else $error("odd half-mode cell not blank");
   chk_right_src: assert property (@(posedge clk) disable iff (!resetn)
      f_issue && f_w_reg == dfm_pkg::DFM_WIDTH_RIGHT |-> f_src[5] && f_src[4:0] == f_col_reg[5:1])
      else $error("right half source column wrong");
   chk_no_steal: assert property (@(posedge clk) disable iff (!resetn)
      in_process && !mem_req_reg |=> !mem_req_reg)
      else $error("steal started while in process");
   chk_blank_video: assert property (@(posedge clk) disable iff (!resetn)
      in_process |=> video_reg == $past(reverse_video))
      else $error("screen not blank while in process");
   chk_data_load: assert property (@(posedge clk) disable iff (!resetn)
      ld_cell && buf_out_valid && !buf_out_data[`DFM_ENT_BLANK] && !buf_out_data[`DFM_ENT_HEX]
      |=> data_reg == $past(buf_out_data[7:0]))
      else $error("data register not loaded from fetched byte");
   chk_reset_state: assert property (@(posedge clk)
      !resetn |=> !mem_req_reg && data_reg == 8'h00 && hcell_reg == 7'h00 && vline_reg == 8'h00)
      else $error("reset did not restart the block");
endmodule

// ==== tb/dfm_mem_model.sv ====
// storage model that answers cycle-steal reads from the display fetch block
// assumes one clock; requests change just after a rising edge
module dfm_mem_model (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        mem_req,
   input  wire logic [15:0] mem_addr,
   input  wire logic [1:0]  lat,
   output logic             mem_ack,
   output logic [7:0]       mem_rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   int wait_cnt;

   // storage contents: every byte differs from its neighbours; address bits 11:8 are folded into the top nibble
   function automatic logic [7:0] fill_byte(input logic [15:0] a);
      return a[7:0] ^ {a[11:8], 4'h5};
   endfunction

   // answer after lat idle cycles; a released data bus flips every cycle
   initial begin
      mem_ack = 1'b0;
      mem_rdata = 8'h00;
      wait_cnt = 0;
      forever begin
         @(posedge clk);
         #1;
         if (!mem_ack && mem_req && resetn && wait_cnt >= int'(lat)) begin
            mem_ack = 1'b1;
            mem_rdata = fill_byte(mem_addr);
            wait_cnt = 0;
         end else begin
            if (mem_req && !mem_ack) wait_cnt++;
            else wait_cnt = 0;
            mem_ack = 1'b0;
            mem_rdata = ~mem_rdata;
         end
      end
   end
endmodule

// ==== tb/test_display_fetch_mode_control.sv ====
// self-checking bench for the display fetch block
// assumes dfm_top and the storage model; dot divider shortened to 2
module test_display_fetch_mode_control;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int D = 2;
   localparam int CELL = 8 * D;
   logic        clk, resetn, left_half_expanded, right_half_expanded;
   logic        reverse_video, display_registers, in_process;
   logic        mem_req, mem_ack, hsync, vsync, video, hsync_q;
   logic [15:0] mem_addr;
   logic [7:0]  mem_rdata, data_code;
   logic [1:0]  lat;
   int          err_count, num_checks, line_cnt, n, w, bad, reqs;

   // *****************************************************
   // design, storage model, clock and line counter
   // *****************************************************
   dfm_top #(.DOT_DIV(D), .DEPTH(2)) dfm_top_i (
      .clk(clk), .resetn(resetn), .left_half_expanded(left_half_expanded),
      .right_half_expanded(right_half_expanded), .reverse_video(reverse_video),
      .display_registers(display_registers), .in_process(in_process),
      .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .data_code(data_code), .hsync(hsync), .vsync(vsync), .video(video));
   dfm_mem_model dfm_mem_model_i (
      .clk(clk), .resetn(resetn), .mem_req(mem_req), .mem_addr(mem_addr), .lat(lat),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // count lines by hsync rises since reset
   always @(posedge clk) begin
      hsync_q <= hsync;
      if (!resetn) line_cnt <= 0;
      else if (hsync && !hsync_q) line_cnt <= line_cnt + 1;
   end

   // *****************************************************
   // tasks
   // *****************************************************
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic fail_msg(input string what);
      err_count++;
      $display("MISMATCH t=%0t %s", $time, what);
   endtask

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
      num_checks++;
      if (got !== exp) fail_msg($sformatf("%s got %h exp %h", what, got, exp));
   endtask

   task automatic cmp1(input logic got, input logic exp, input string what);
      num_checks++;
      if (got !== exp) fail_msg($sformatf("%s got %b exp %b", what, got, exp));
   endtask

   task automatic cmp_cnt(input int got, input int exp, input string what);
      num_checks++;
      if (got != exp) fail_msg($sformatf("%s got %0d exp %0d", what, got, exp));
   endtask

   task automatic set_mode(input logic l, input logic r, input logic hex,
                           input logic rev, input logic ip);
      left_half_expanded = l;
      right_half_expanded = r;
      display_registers = hex;
      reverse_video = rev;
      in_process = ip;
   endtask

   // wait, bounded, for the next rising edge of hsync
   task automatic wait_hsync;
      int k;
      k = 0;
      tick(1);
      while (!(hsync === 1'b1 && hsync_q === 1'b0) && k < 4000) begin
         tick(1);
         k++;
      end
      if (k >= 4000) fail_msg("hsync missing");
   endtask

   // expected code: 0 full, 1 left, 2 right, 3 hex
   function automatic logic [7:0] exp_char(input int kind, input int row, input int c);
      logic [7:0] b;
      logic [3:0] nib;
      if ((kind == 1 || kind == 2) && c[0]) return 8'h20;
      if (kind == 0) return dfm_mem_model_i.fill_byte(16'(16'h0200 + row * 64 + c));
      if (kind == 1) return dfm_mem_model_i.fill_byte(16'(16'h0200 + row * 64 + c / 2));
      if (kind == 2) return dfm_mem_model_i.fill_byte(16'(16'h0200 + row * 64 + 32 + c / 2));
      b = dfm_mem_model_i.fill_byte(16'(row * 32 + c / 2));
      nib = c[0] ? b[3:0] : b[7:4];
      return (nib < 4'hA) ? 8'(8'h30 + nib) : 8'(8'h37 + nib);
   endfunction

   // compare the data register in the middle of every visible cell of the next line
   task automatic check_line(input int kind);
      int row;
      wait_hsync();
      row = (line_cnt + 1) / 12;
      tick(12 * CELL + CELL / 2);
      for (int c = 0; c < 64; c++) begin
         cmp8(data_code, exp_char(kind, row, c), $sformatf("code col %0d", c));
         tick(CELL);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // *****************************************************
   // tests
   // *****************************************************
   initial begin
      err_count = 0;
      num_checks = 0;
      resetn = 1'b0;
      lat = 2'h0;
      set_mode(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      tick(8);
      cmp8(data_code, 8'h00, "reset code");
      cmp1(mem_req, 1'b0, "reset req");
      resetn = 1'b1;
      $display("test reset done");
      wait_hsync();
      w = 0;
      while (hsync === 1'b1 && w < 2000) begin
         tick(1);
         w++;
      end
      n = w;
      while (!(hsync === 1'b1 && hsync_q === 1'b0) && n < 4000) begin
         tick(1);
         n++;
      end
      cmp_cnt(w, 48 * D, "hsync width");
      cmp_cnt(n, 640 * D, "line period");
      cmp1(vsync, 1'b0, "vsync early");
      $display("test sync done");
      check_line(0); // full width
      set_mode(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      lat = 2'h3;
      wait_hsync();
      check_line(1); // left half with slow storage
      set_mode(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
      lat = 2'h1;
      wait_hsync();
      check_line(2); // right half
      $display("test widths done");
      set_mode(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      lat = 2'h2;
      wait_hsync();
      check_line(3); // hex view
      $display("test hex done");
      set_mode(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
      wait_hsync();
      tick(4);
      cmp1(video, 1'b1, "reverse background");
      reverse_video = 1'b0;
      tick(3);
      cmp1(video, 1'b0, "normal background");
      $display("test reverse done");
      set_mode(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
      tick(2);
      cmp1(video, 1'b1, "blank in process");
      wait_hsync();
      wait_hsync();
      bad = 0;
      reqs = 0;
      for (int i = 0; i < 640 * D; i++) begin
         if (mem_req !== 1'b0) reqs++;
         if (video !== 1'b1) bad++;
         tick(1);
      end
      cmp_cnt(reqs, 0, "steals in process");
      cmp_cnt(bad, 0, "lit dots in process");
      set_mode(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      wait_hsync();
      check_line(0); // fetch resumes
      $display("test in process done");
      tick(300);
      resetn = 1'b0;
      tick(1);
      cmp8(data_code, 8'h00, "mid reset code");
      cmp1(mem_req, 1'b0, "mid reset req");
      cmp1(hsync, 1'b0, "mid reset hsync");
      cmp1(video, 1'b0, "mid reset video");
      tick(2);
      set_mode(1'b1, 1'b1, 1'b0, 1'b0, 1'b0); // both halves high falls back to full
      resetn = 1'b1;
      n = 0;
      while (!(hsync === 1'b1 && hsync_q === 1'b0) && n < 4000) begin
         tick(1);
         n++;
      end
      cmp_cnt(int'(n >= 68 * CELL - 2 && n <= 68 * CELL + 2), 1, "first hsync");
      check_line(0); // first row again, both halves high
      $display("test second reset done");
      wrap_up();
   end

   // watchdog well beyond the expected run
   initial begin
      repeat (60000) @(posedge clk);
      fail_msg("watchdog expired");
      wrap_up();
   end
endmodule
